/* File: rtl/aod_consts.vh */
// Constants for the add and shift operand datapath
`ifndef AOD_CONSTS_VH
`define AOD_CONSTS_VH
// Operation codes from the decoder
`define AOD_OP_ADD 4'h1
`define AOD_OP_SUM_WITH_CARRY_IN 4'h2
`define AOD_OP_ACC_SUM 4'h3
`define AOD_OP_ACC_SRC 4'h4
`define AOD_OP_ASR1 4'h5
`define AOD_OP_ASR_BAR 4'h6
`define AOD_OP_MPY 4'h7
`define AOD_OP_SQR 4'h8
`define AOD_OP_DIV 4'h9
// Operand forms
`define AOD_FORM_FILE 2'h0
`define AOD_FORM_REG 2'h1
`define AOD_FORM_SHORT_LITERAL 2'h2
`define AOD_FORM_MEDIUM_LITERAL 2'h3
// Addressing modes
`define AOD_AM_IND 3'h1
`define AOD_AM_POSTINC 3'h2
`define AOD_AM_POSTDEC 3'h3
`define AOD_AM_PREINC 3'h4
`define AOD_AM_PREDEC 3'h5
`define AOD_AM_OFFSET 3'h6
`define AOD_STEP_WORD 16'h0002
`define AOD_STEP_BYTE 16'h0001
// Prefetch codes, bit 3 picks the second pointer; with code 0 it only enables the offset fetch from the second pointer
`define AOD_PF_NONE_OFS 3'h0
`define AOD_PF_PLAIN 3'h1
`define AOD_PF_INC2 3'h2
`define AOD_PF_INC4 3'h3
`define AOD_PF_INC6 3'h4
`define AOD_PF_DEC2 3'h5
`define AOD_PF_DEC4 3'h6
`define AOD_PF_DEC6 3'h7
`define AOD_PF_STEP2 16'h0002
`define AOD_PF_STEP4 16'h0004
`define AOD_PF_STEP6 16'h0006
// Working register numbers
`define AOD_W_COUNT 16
`define AOD_W_RESET 16'h0000
`define AOD_W_DEFAULT 4'h0
`define AOD_W_REMAINDER 4'h1
`define AOD_W4 4'h4
`define AOD_W5 4'h5
`define AOD_W6 4'h6
`define AOD_W7 4'h7
`define AOD_W_X0 4'h8
`define AOD_W_X1 4'h9
`define AOD_W_Y0 4'ha
`define AOD_W_Y1 4'hb
`define AOD_W_PF_OFS 4'hc
// Data memory
`define AOD_MEM_WORDS 64
`define AOD_MEM_MSB 6
// Bus word indices, address bit 8 selects data memory
`define AOD_REG_W_TOP 2'h0
`define AOD_REG_STATUS 6'h10
`define AOD_REG_CONTROL 6'h11
`define AOD_REG_ACCA_LO 6'h12
`define AOD_REG_ACCA_HI 6'h13
`define AOD_REG_ACCB_LO 6'h14
`define AOD_REG_ACCB_HI 6'h15
// Status bit positions
`define AOD_SR_C 0
`define AOD_SR_Z 1
`define AOD_SR_OV 2
`define AOD_SR_N 3
`define AOD_SR_DC 4
`define AOD_SR_OA 8
`define AOD_SR_OB 9
`define AOD_SR_SA 10
`define AOD_SR_SB 11
`define AOD_CTL_SAT 0
// Accumulator limits
`define AOD_ACC_RESET 40'h00_0000_0000
`define AOD_ACC_MAX 40'h00_7fff_ffff
`define AOD_ACC_MIN 40'hff_8000_0000
`endif

/* File: rtl/aod_agen.v */
// Effective address and pointer update for one indirect operand
`timescale 1ns/1ns
`default_nettype none
`include "aod_consts.vh"

module aod_agen (
	input wire [15:0] ptr,
	input wire [15:0] base,
	input wire [2:0] mode,
	input wire byte_mode,
	output reg [15:0] ea,
	output reg [15:0] next_ptr,
	output reg indirect,
	output reg update
);

wire [15:0] step = byte_mode ? `AOD_STEP_BYTE : `AOD_STEP_WORD;

// Mode decode; unknown codes fall back to direct
always @* begin
	ea = ptr;
	next_ptr = ptr;
	indirect = 1'b1;
	update = 1'b0;
	case (mode)
	`AOD_AM_IND: ;
	`AOD_AM_POSTINC: begin
		next_ptr = ptr + step;
		update = 1'b1;
	end
	`AOD_AM_POSTDEC: begin
		next_ptr = ptr - step;
		update = 1'b1;
	end
	`AOD_AM_PREINC: begin
		ea = ptr + step;
		next_ptr = ptr + step;
		update = 1'b1;
	end
	`AOD_AM_PREDEC: begin
		ea = ptr - step;
		next_ptr = ptr - step;
		update = 1'b1;
	end
	`AOD_AM_OFFSET: ea = ptr + base;
	default: indirect = 1'b0;
	endcase
end

endmodule // aod_agen
`default_nettype wire

/* File: rtl/aod_datapath.v */
// Add and shift operand datapath with Avalon-MM register slave
`timescale 1ns/1ns
`default_nettype none
`include "aod_consts.vh"

module aod_datapath (
	input wire clock,
	input wire reset,
	input wire [8:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output reg waitrequest,
	input wire instr_valid,
	input wire [3:0] op_code,
	input wire [1:0] op_form,
	input wire byte_mode,
	input wire [3:0] base_register,
	input wire [3:0] source_operand,
	input wire [2:0] source_mode,
	input wire [3:0] destination_operand,
	input wire [2:0] destination_mode,
	input wire [12:0] file_address,
	input wire to_default_working_register,
	input wire [4:0] short_literal,
	input wire [9:0] medium_literal,
	input wire acc_select,
	input wire [3:0] acc_shift,
	input wire [2:0] multiply_select,
	input wire [3:0] x_prefetch_pointer,
	input wire [1:0] x_prefetch_dest,
	input wire [3:0] y_prefetch_pointer,
	input wire [1:0] y_prefetch_dest,
	output reg instr_done
);

// ****************************************
// Helpers
// ****************************************

// Byte mode reads one lane, zero above
function [15:0] pick_operand;
	input [15:0] word;
	input hi;
	input bm;
	begin
		if (bm) begin
			pick_operand = {8'h00, hi ? word[15:8] : word[7:0]};
		end else begin
			pick_operand = word;
		end
	end
endfunction

// Bus byte lanes onto a 16-bit register
function [15:0] merge16;
	input [15:0] old;
	input [15:0] wdata;
	input [1:0] be;
	begin
		merge16 = {be[1] ? wdata[15:8] : old[15:8], be[0] ? wdata[7:0] : old[7:0]};
	end
endfunction

// Prefetch decode: {valid, update, address, new pointer}
function [33:0] pf_calc;
	input [3:0] code;
	input [15:0] p0;
	input [15:0] p1;
	input [15:0] ofs;
	reg [15:0] p;
	begin
		p = code[3] ? p1 : p0;
		case (code[2:0])
		`AOD_PF_NONE_OFS: pf_calc = {code[3], 1'b0, p1 + ofs, p1};
		`AOD_PF_PLAIN: pf_calc = {2'b10, p, p};
		`AOD_PF_INC2: pf_calc = {2'b11, p, p + `AOD_PF_STEP2};
		`AOD_PF_INC4: pf_calc = {2'b11, p, p + `AOD_PF_STEP4};
		`AOD_PF_INC6: pf_calc = {2'b11, p, p + `AOD_PF_STEP6};
		`AOD_PF_DEC2: pf_calc = {2'b11, p, p - `AOD_PF_STEP2};
		`AOD_PF_DEC4: pf_calc = {2'b11, p, p - `AOD_PF_STEP4};
		default: pf_calc = {2'b11, p, p - `AOD_PF_STEP6};
		endcase
	end
endfunction

// Multiplier register pair, square repeats one register
function [7:0] mul_pair;
	input square;
	input [2:0] sel;
	begin
		if (square) begin
			mul_pair = {2{2'b01, sel[1:0]}};
		end else begin
			case (sel)
			3'h0: mul_pair = {`AOD_W4, `AOD_W5};
			3'h1: mul_pair = {`AOD_W4, `AOD_W6};
			3'h2: mul_pair = {`AOD_W4, `AOD_W7};
			3'h3: mul_pair = {`AOD_W5, `AOD_W6};
			3'h4: mul_pair = {`AOD_W5, `AOD_W7};
			default: mul_pair = {`AOD_W6, `AOD_W7};
			endcase
		end
	end
endfunction

// Word-slot decode on the control page
function bus_hit;
	input [8:0] addr;
	input [5:0] idx;
	begin
		bus_hit = ~addr[8] & (addr[7:2] == idx);
	end
endfunction

// ****************************************
// State
// ****************************************

wire [15:0] wr [0:`AOD_W_COUNT-1];
reg [15:0] data_mem [0:`AOD_MEM_WORDS-1];
reg [39:0] acc_a;
reg [39:0] acc_b;
reg flag_c, flag_dc, flag_n, flag_ov, flag_z;
reg acc_a_overflow, acc_b_overflow, acc_a_clipped, acc_b_clipped;
reg sat_enable;
reg next_c, next_dc, next_n, next_ov, next_z;
reg next_oa, next_ob, next_sa, next_sb;
reg res_we, res_mem_we, rem_we, acc_we;
reg [3:0] res_idx;
reg [15:0] res_raw;
reg [15:0] op_a, op_b;
reg dest_mem;
reg [3:0] dest_idx;
reg [15:0] dest_addr;
reg [31:0] bus_rd_val;

// ****************************************
// Operand paths
// ****************************************

wire [15:0] src_ea, src_np, dst_ea, dst_np;
wire src_ind, src_upd, dst_ind, dst_upd;

aod_agen u_src_agen (
	.ptr(wr[source_operand]),
	.base(wr[base_register]),
	.mode(source_mode),
	.byte_mode(byte_mode),
	.ea(src_ea),
	.next_ptr(src_np),
	.indirect(src_ind),
	.update(src_upd)
);

aod_agen u_dst_agen (
	.ptr(wr[destination_operand]),
	.base(wr[base_register]),
	.mode(destination_mode),
	.byte_mode(byte_mode),
	.ea(dst_ea),
	.next_ptr(dst_np),
	.indirect(dst_ind),
	.update(dst_upd)
);

// Operation classes
wire is_add = (op_code == `AOD_OP_ADD) | (op_code == `AOD_OP_SUM_WITH_CARRY_IN);
wire is_asr1 = op_code == `AOD_OP_ASR1;
wire is_bar = op_code == `AOD_OP_ASR_BAR;
wire is_dsp = (op_code == `AOD_OP_MPY) | (op_code == `AOD_OP_SQR);
wire is_acc = is_dsp | (op_code == `AOD_OP_ACC_SUM) | (op_code == `AOD_OP_ACC_SRC);
wire form_reg = op_form == `AOD_FORM_REG;
wire res_byte = byte_mode & (is_add | is_asr1);

// Source and file operands
wire [15:0] src_word = src_ind ? data_mem[src_ea[`AOD_MEM_MSB:1]] : wr[source_operand];
wire [15:0] src_val = pick_operand(src_word, src_ind & src_ea[0], byte_mode);
wire [15:0] file_val = pick_operand(data_mem[file_address[`AOD_MEM_MSB:1]], file_address[0], byte_mode);

// Pointer side effects only for operands actually used
wire uses_src = ((is_add | is_asr1) & form_reg) | (op_code == `AOD_OP_ACC_SRC);
wire uses_dst = (is_add & (form_reg | (op_form == `AOD_FORM_SHORT_LITERAL))) | (is_asr1 & form_reg);
wire src_ptr_we = instr_valid & uses_src & src_upd;
wire dst_ptr_we = instr_valid & uses_dst & dst_upd;

// Add operands per form
always @* begin
	case (op_form)
	`AOD_FORM_FILE: begin
		op_a = file_val;
		op_b = pick_operand(wr[`AOD_W_DEFAULT], 1'b0, byte_mode);
	end
	`AOD_FORM_REG: begin
		op_a = pick_operand(wr[base_register], 1'b0, byte_mode);
		op_b = src_val;
	end
	`AOD_FORM_SHORT_LITERAL: begin
		op_a = pick_operand(wr[base_register], 1'b0, byte_mode);
		op_b = {11'h000, short_literal};
	end
	default: begin
		op_a = pick_operand(wr[destination_operand], 1'b0, byte_mode);
		op_b = {6'h00, medium_literal};
	end
	endcase
end

// Destination routing for add and single shift
always @* begin
	if (op_form == `AOD_FORM_FILE) begin
		dest_mem = ~to_default_working_register;
		dest_idx = `AOD_W_DEFAULT;
		dest_addr = {3'h0, file_address};
	end else begin
		dest_mem = (op_form != `AOD_FORM_MEDIUM_LITERAL) & dst_ind;
		dest_idx = destination_operand;
		dest_addr = dst_ea;
	end
end

// ****************************************
// Integer arithmetic
// ****************************************

wire add_cin = (op_code == `AOD_OP_SUM_WITH_CARRY_IN) & flag_c;
wire [16:0] sum_w = {1'b0, op_a} + {1'b0, op_b} + {16'h0000, add_cin};
wire [8:0] sum_b = {1'b0, op_a[7:0]} + {1'b0, op_b[7:0]} + {8'h00, add_cin};
wire [4:0] sum_n = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, add_cin};
wire [15:0] add_r = byte_mode ? {8'h00, sum_b[7:0]} : sum_w[15:0];
wire [15:0] asr_in = (op_form == `AOD_FORM_FILE) ? file_val : src_val;
wire [15:0] asr_r = byte_mode ? {8'h00, asr_in[7], asr_in[7:1]} : {asr_in[15], asr_in[15:1]};
wire [15:0] bar_r = $signed(wr[base_register]) >>> wr[source_operand][3:0];
wire [15:0] alu_r = is_asr1 ? asr_r : (is_bar ? bar_r : add_r);
wire res_sign = res_byte ? alu_r[7] : alu_r[15];
wire res_zero = res_byte ? (alu_r[7:0] == 8'h00) : (alu_r == 16'h0000);
wire add_ov = byte_mode ? ((op_a[7] == op_b[7]) & (add_r[7] != op_a[7]))
	: ((op_a[15] == op_b[15]) & (add_r[15] != op_a[15]));

// Byte results keep the other lane of the target
wire [15:0] dest_old = dest_mem ? data_mem[dest_addr[`AOD_MEM_MSB:1]] : wr[dest_idx];
wire dest_hi = dest_mem & dest_addr[0];
wire [15:0] res_val = res_byte ? (dest_hi ? {res_raw[7:0], dest_old[7:0]} : {dest_old[15:8], res_raw[7:0]})
	: res_raw;

// Divide on a directly addressed pair; zero divisor gives an all-ones quotient and the dividend as remainder
wire [15:0] div_m = wr[base_register];
wire [15:0] div_n = wr[source_operand];
wire div_zero = div_n == 16'h0000;
wire [15:0] div_q = div_zero ? 16'hffff : div_m / div_n;
wire [15:0] div_r = div_zero ? div_m : div_m % div_n;

// ****************************************
// Accumulator path
// ****************************************

wire [7:0] mul_ix = mul_pair(op_code == `AOD_OP_SQR, multiply_select);
wire signed [31:0] mul_p = $signed(wr[mul_ix[7:4]]) * $signed(wr[mul_ix[3:0]]);
wire [39:0] acc_cur = acc_select ? acc_b : acc_a;
wire [39:0] src_acc = {{8{src_word[15]}}, src_word, 16'h0000};
wire [3:0] shl_amt = 4'h0 - acc_shift;
wire [39:0] src_sh = acc_shift[3] ? $signed(src_acc << shl_amt) : ($signed(src_acc) >>> acc_shift); // Both arms signed
wire [39:0] acc_x = is_dsp ? `AOD_ACC_RESET : ((op_code == `AOD_OP_ACC_SUM) ? acc_a : acc_cur);
wire [39:0] acc_y = is_dsp ? {{8{mul_p[31]}}, mul_p} : ((op_code == `AOD_OP_ACC_SUM) ? acc_b : src_sh);
wire [40:0] acc_sum = {acc_x[39], acc_x} + {acc_y[39], acc_y};
wire acc_cat = acc_sum[40] ^ acc_sum[39];
wire acc_ovf = ~((&acc_sum[39:31]) | ~(|acc_sum[39:31]));
wire acc_sat = sat_enable & (acc_cat | acc_ovf);
wire acc_clip = acc_cat | acc_sat;
wire [39:0] acc_new = acc_sat ? (acc_sum[40] ? `AOD_ACC_MIN : `AOD_ACC_MAX) : acc_sum[39:0];

// ****************************************
// Prefetch
// ****************************************

wire [33:0] xpf = pf_calc(x_prefetch_pointer, wr[`AOD_W_X0], wr[`AOD_W_X1], wr[`AOD_W_PF_OFS]);
wire [33:0] ypf = pf_calc(y_prefetch_pointer, wr[`AOD_W_Y0], wr[`AOD_W_Y1], wr[`AOD_W_PF_OFS]);
wire x_dat_we = instr_valid & is_dsp & xpf[33];
wire y_dat_we = instr_valid & is_dsp & ypf[33];
wire x_ptr_we = x_dat_we & xpf[32];
wire y_ptr_we = y_dat_we & ypf[32];
wire [3:0] x_ptr_idx = x_prefetch_pointer[3] ? `AOD_W_X1 : `AOD_W_X0;
wire [3:0] y_ptr_idx = y_prefetch_pointer[3] ? `AOD_W_Y1 : `AOD_W_Y0;
wire [3:0] x_dat_idx = {2'b01, x_prefetch_dest};
wire [3:0] y_dat_idx = {2'b01, y_prefetch_dest};
wire [15:0] x_dat = data_mem[xpf[16+`AOD_MEM_MSB:17]];
wire [15:0] y_dat = data_mem[ypf[16+`AOD_MEM_MSB:17]];

// ****************************************
// Bus slave
// ****************************************

wire bus_commit = write & ~waitrequest;
wire w_hit = ~address[8] & (address[7:6] == `AOD_REG_W_TOP);
wire bus_w_we = bus_commit & w_hit;
wire bus_m_we = bus_commit & address[8];
wire st_wr_lo = bus_commit & bus_hit(address, `AOD_REG_STATUS) & byteenable[0];
wire st_wr_hi = bus_commit & bus_hit(address, `AOD_REG_STATUS) & byteenable[1];

// Read mux, unmapped slots read zero
always @* begin
	bus_rd_val = 32'h0000_0000;
	if (address[8]) begin
		bus_rd_val = {16'h0000, data_mem[address[7:2]]};
	end else if (w_hit) begin
		bus_rd_val = {16'h0000, wr[address[5:2]]};
	end else if (bus_hit(address, `AOD_REG_STATUS)) begin
		bus_rd_val[`AOD_SR_C] = flag_c;
		bus_rd_val[`AOD_SR_Z] = flag_z;
		bus_rd_val[`AOD_SR_OV] = flag_ov;
		bus_rd_val[`AOD_SR_N] = flag_n;
		bus_rd_val[`AOD_SR_DC] = flag_dc;
		bus_rd_val[`AOD_SR_OA] = acc_a_overflow;
		bus_rd_val[`AOD_SR_OB] = acc_b_overflow;
		bus_rd_val[`AOD_SR_SA] = acc_a_clipped;
		bus_rd_val[`AOD_SR_SB] = acc_b_clipped;
	end else if (bus_hit(address, `AOD_REG_CONTROL)) begin
		bus_rd_val[`AOD_CTL_SAT] = sat_enable;
	end else if (bus_hit(address, `AOD_REG_ACCA_LO)) begin
		bus_rd_val = acc_a[31:0];
	end else if (bus_hit(address, `AOD_REG_ACCA_HI)) begin
		bus_rd_val = {24'h000000, acc_a[39:32]};
	end else if (bus_hit(address, `AOD_REG_ACCB_LO)) begin
		bus_rd_val = acc_b[31:0];
	end else if (bus_hit(address, `AOD_REG_ACCB_HI)) begin
		bus_rd_val = {24'h000000, acc_b[39:32]};
	end
end

// One wait state: answer in the second cycle of each request; read data holds across writes
always @(posedge clock or posedge reset) begin
	if (reset) begin
		waitrequest <= 1'b1;
		readdata <= 32'h0000_0000;
	end else if ((read | write) & waitrequest) begin
		waitrequest <= 1'b0;
		if (read) begin
			readdata <= bus_rd_val;
		end
	end else begin
		waitrequest <= 1'b1;
	end
end

// ****************************************
// Execute
// ****************************************

// Flag and write decisions; instruction beats a same-cycle bus write
always @* begin
	res_we = 1'b0;
	res_mem_we = 1'b0;
	rem_we = 1'b0;
	acc_we = 1'b0;
	res_idx = dest_idx;
	res_raw = alu_r;
	next_c = st_wr_lo ? writedata[`AOD_SR_C] : flag_c;
	next_z = st_wr_lo ? writedata[`AOD_SR_Z] : flag_z;
	next_ov = st_wr_lo ? writedata[`AOD_SR_OV] : flag_ov;
	next_n = st_wr_lo ? writedata[`AOD_SR_N] : flag_n;
	next_dc = st_wr_lo ? writedata[`AOD_SR_DC] : flag_dc;
	next_oa = st_wr_hi ? writedata[`AOD_SR_OA] : acc_a_overflow;
	next_ob = st_wr_hi ? writedata[`AOD_SR_OB] : acc_b_overflow;
	next_sa = st_wr_hi ? writedata[`AOD_SR_SA] : acc_a_clipped;
	next_sb = st_wr_hi ? writedata[`AOD_SR_SB] : acc_b_clipped;
	if (instr_valid) begin
		if (is_add | is_asr1) begin
			res_we = ~dest_mem;
			res_mem_we = dest_mem;
			next_n = res_sign;
			next_z = res_zero;
		end
		if (is_add) begin
			next_c = res_byte ? sum_b[8] : sum_w[16];
			next_dc = res_byte ? sum_n[4] : sum_b[8];
			next_ov = add_ov;
			if (op_code == `AOD_OP_SUM_WITH_CARRY_IN) begin
				next_z = flag_z & res_zero;
			end
		end else if (is_asr1) begin
			next_c = asr_in[0];
			next_ov = 1'b0;
		end else if (is_bar) begin
			res_we = 1'b1;
			res_idx = destination_operand;
			next_n = res_sign;
			next_z = res_zero;
		end else if (op_code == `AOD_OP_DIV) begin
			res_we = 1'b1;
			res_idx = `AOD_W_DEFAULT;
			res_raw = div_q;
			rem_we = 1'b1;
		end else if (is_acc) begin
			acc_we = 1'b1;
			if (acc_select) begin
				next_ob = acc_ovf | acc_cat;
				next_sb = next_sb | acc_clip;
			end else begin
				next_oa = acc_ovf | acc_cat;
				next_sa = next_sa | acc_clip;
			end
		end
	end
end

// Flags, accumulators and control
always @(posedge clock or posedge reset) begin
	if (reset) begin
		{flag_c, flag_dc, flag_n, flag_ov, flag_z} <= 5'h00;
		{acc_a_overflow, acc_b_overflow, acc_a_clipped, acc_b_clipped} <= 4'h0;
		acc_a <= `AOD_ACC_RESET;
		acc_b <= `AOD_ACC_RESET;
		sat_enable <= 1'b0;
		instr_done <= 1'b0;
	end else begin
		{flag_c, flag_dc, flag_n, flag_ov, flag_z} <= {next_c, next_dc, next_n, next_ov, next_z};
		{acc_a_overflow, acc_b_overflow, acc_a_clipped, acc_b_clipped} <= {next_oa, next_ob, next_sa, next_sb};
		if (acc_we & ~acc_select) begin
			acc_a <= acc_new;
		end
		if (acc_we & acc_select) begin
			acc_b <= acc_new;
		end
		if (bus_commit & bus_hit(address, `AOD_REG_CONTROL) & byteenable[0]) begin
			sat_enable <= writedata[`AOD_CTL_SAT];
		end
		instr_done <= instr_valid;
	end
end

// Sixteen working registers; result beats pointer updates beats bus
genvar gi;
generate
	for (gi = 0; gi < `AOD_W_COUNT; gi = gi + 1) begin : g_default_working_register
		localparam [3:0] IDX = gi;
		reg [15:0] q;
		assign wr[gi] = q;
		always @(posedge clock or posedge reset) begin
			if (reset) begin
				q <= `AOD_W_RESET;
			end else if (res_we && res_idx == IDX) begin
				q <= res_val;
			end else if (rem_we && IDX == `AOD_W_REMAINDER) begin
				q <= div_r;
			end else if (x_dat_we && x_dat_idx == IDX) begin
				q <= x_dat;
			end else if (y_dat_we && y_dat_idx == IDX) begin
				q <= y_dat;
			end else if (dst_ptr_we && destination_operand == IDX) begin
				q <= dst_np;
			end else if (src_ptr_we && source_operand == IDX) begin
				q <= src_np;
			end else if (x_ptr_we && x_ptr_idx == IDX) begin
				q <= xpf[15:0];
			end else if (y_ptr_we && y_ptr_idx == IDX) begin
				q <= ypf[15:0];
			end else if (bus_w_we && address[5:2] == IDX) begin
				q <= merge16(q, writedata[15:0], byteenable[1:0]);
			end
		end
	end
endgenerate

wire [`AOD_MEM_MSB-1:0] res_addr_idx = dest_addr[`AOD_MEM_MSB:1];

// Data memory; an instruction store wins over a bus store
always @(posedge clock) begin
	if (res_mem_we) begin
		data_mem[res_addr_idx] <= res_val;
	end else if (bus_m_we) begin
		data_mem[address[7:2]] <= merge16(data_mem[address[7:2]], writedata[15:0], byteenable[1:0]);
	end
end

endmodule // aod_datapath
`default_nettype wire

/* File: testbench/aod_asserts.sv */
// Port checks for the operand datapath
`timescale 1ns/1ns
`default_nettype none
module aod_asserts (
	input wire logic clock,
	input wire logic reset,
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	input wire logic [31:0] readdata,
	input wire logic instr_valid,
	input wire logic instr_done
);
	// ****************
	// Bus and instruction timing
	// ****************
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	chk_done_next: assert property (instr_valid |=> instr_done) else $error("done late");
	chk_done_cause: assert property (instr_done |-> $past(instr_valid)) else $error("stray done");
	chk_done_once: assert property (instr_valid ##1 !instr_valid |=> !instr_done) else $error("done long");
	chk_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
	chk_wait_single: assert property (!waitrequest |=> waitrequest) else $error("wait low twice");
	chk_wait_cause: assert property (!waitrequest |-> $past(read || write)) else $error("stray answer");
	chk_wait_idle: assert property (!read && !write |-> waitrequest) else $error("idle answer");
	// Read data may only move on the edge that takes a read
	chk_rdata_hold: assert property ($changed(readdata) |-> $past(read && waitrequest)) else $error("data moved");
	cov_instr: cover property (instr_valid ##1 instr_done);
	cov_read: cover property (read && !waitrequest);
	cov_write: cover property (write && !waitrequest);
endmodule // aod_asserts
`default_nettype wire

/* File: testbench/aod_seq_model.sv */
// Decoder model issuing one instruction per call
`timescale 1ns/1ns
`default_nettype none
module aod_seq_model (
	input wire logic clock,
	output logic instr_valid,
	output logic [3:0] op_code,
	output logic [1:0] op_form,
	output logic [3:0] base_register,
	output logic [3:0] source_operand,
	output logic [2:0] source_mode,
	output logic [3:0] destination_operand,
	output logic [2:0] destination_mode,
	output logic [12:0] file_address,
	output logic to_default_working_register,
	output logic [4:0] short_literal,
	output logic [2:0] multiply_select
);
	// Quiet until the first call
	initial begin
		{instr_valid, op_code, op_form, base_register, source_operand, source_mode} = '0;
		{destination_operand, destination_mode, file_address, to_default_working_register} = '0;
		{short_literal, multiply_select} = '0;
	end
	// Fields stay from the one-cycle valid pulse until the next call; pair select rides on the source number
	task issue(input logic [3:0] op, input logic [1:0] fm, input logic [3:0] b, input logic [3:0] s,
		input logic [2:0] sm, input logic [3:0] d, input logic [2:0] dm, input logic [4:0] lit,
		input logic [12:0] fa, input logic tw);
		@(posedge clock);
		{op_code, op_form, base_register, source_operand, source_mode} <= {op, fm, b, s, sm};
		{destination_operand, destination_mode, file_address, to_default_working_register} <= {d, dm, fa, tw};
		short_literal <= lit;
		multiply_select <= s[2:0];
		instr_valid <= 1'b1;
		@(posedge clock);
		instr_valid <= 1'b0;
	endtask
endmodule // aod_seq_model
`default_nettype wire

/* File: testbench/aod_datapath_test.sv */
// Self-checking bench for the operand datapath
`timescale 1ns/1ns
`default_nettype none
module aod_datapath_test;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [8:0] address = 9'h000;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [3:0] byteenable = 4'h0;
	logic [15:0] q;
	logic bm = 1'b0;
	logic [3:0] pfx = 4'h0;
	wire logic [31:0] readdata;
	wire logic waitrequest, instr_valid, instr_done, to_default_working_register;
	wire logic [3:0] op_code, base_register, source_operand, destination_operand;
	wire logic [2:0] source_mode, destination_mode, multiply_select;
	wire logic [1:0] op_form;
	wire logic [12:0] file_address;
	wire logic [4:0] short_literal;
	int num_errors = 0;
	int n_checks = 0;
	aod_seq_model u_seq (.clock(clock), .instr_valid(instr_valid), .op_code(op_code), .op_form(op_form),
		.base_register(base_register), .source_operand(source_operand), .source_mode(source_mode),
		.destination_operand(destination_operand), .destination_mode(destination_mode),
		.file_address(file_address), .to_default_working_register(to_default_working_register),
		.short_literal(short_literal), .multiply_select(multiply_select));
	aod_datapath uut (.clock(clock), .reset(reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.instr_valid(instr_valid), .op_code(op_code), .op_form(op_form), .byte_mode(bm),
		.base_register(base_register), .source_operand(source_operand), .source_mode(source_mode),
		.destination_operand(destination_operand), .destination_mode(destination_mode),
		.file_address(file_address), .to_default_working_register(to_default_working_register),
		.short_literal(short_literal), .medium_literal({5'h00, short_literal}), .acc_select(1'b0),
		.acc_shift(4'h0), .multiply_select(multiply_select), .x_prefetch_pointer(pfx),
		.x_prefetch_dest(multiply_select[1:0]), .y_prefetch_pointer(4'h0),
		.y_prefetch_dest(multiply_select[1:0]), .instr_done(instr_done));
	// ****************
	// Clock, tasks and watchdog
	// ****************
	// 50 ns period
	always #25 clock = ~clock;
	task check(input logic [8:0] a, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %h: expected %h, seen %h", a, exp, seen);
		end
	endtask
	// Request held until waitrequest is sampled low; a lost answer is bounded
	task xfer(input logic wr, input logic [8:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clock);
		{write, read, address, writedata, byteenable} <= {wr, !wr, a, 16'h0000, d, 4'h3};
		@(posedge clock);
		while (waitrequest !== 1'b0 && n < 20) begin
			@(posedge clock);
			n++;
		end
		if (n == 20) num_errors++;
		q = readdata[15:0];
		{write, read} <= 2'b00;
	endtask
	task wr(input logic [8:0] a, input logic [15:0] d);
		xfer(1'b1, a, d);
	endtask
	task rd(input logic [8:0] a, input logic [15:0] e);
		xfer(1'b0, a, 16'h0000);
		check(a, q, e);
	endtask
	task end_of_test();
		$display("checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Tests need under two hundred cycles
	initial begin
		repeat (4000) @(posedge clock);
		num_errors++;
		end_of_test();
	end
	// ****************
	// Tests
	// ****************
	initial begin
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		rd(9'h000, 16'h0000);
		rd(9'h040, 16'h0000);
		wr(9'h058, 16'hffff);
		rd(9'h058, 16'h0000);
		$display("reset test done");
		wr(9'h008, 16'h7ffe);
		u_seq.issue(4'h1, 2'h2, 4'h2, 4'h0, 3'h0, 4'h3, 3'h0, 5'h03, 13'h0000, 1'b0);
		rd(9'h00c, 16'h8001);
		rd(9'h040, 16'h001c);
		wr(9'h040, 16'h0003);
		wr(9'h008, 16'hffff);
		u_seq.issue(4'h2, 2'h2, 4'h2, 4'h0, 3'h0, 4'h3, 3'h0, 5'h1f, 13'h0000, 1'b0);
		rd(9'h00c, 16'h001f);
		rd(9'h040, 16'h0011);
		$display("literal test done");
		wr(9'h108, 16'h0005);
		wr(9'h000, 16'h0003);
		u_seq.issue(4'h1, 2'h0, 4'h0, 4'h0, 3'h0, 4'h0, 3'h0, 5'h00, 13'h0004, 1'b0);
		rd(9'h108, 16'h0008);
		u_seq.issue(4'h1, 2'h0, 4'h0, 4'h0, 3'h0, 4'h0, 3'h0, 5'h00, 13'h0004, 1'b1);
		rd(9'h000, 16'h000b);
		$display("file test done");
		wr(9'h108, 16'h8003);
		u_seq.issue(4'h5, 2'h0, 4'h0, 4'h0, 3'h0, 4'h0, 3'h0, 5'h00, 13'h0004, 1'b1);
		rd(9'h000, 16'hc001);
		rd(9'h108, 16'h8003);
		rd(9'h040, 16'h0009);
		wr(9'h040, 16'h0015);
		wr(9'h008, 16'h8000);
		wr(9'h010, 16'h0004);
		u_seq.issue(4'h6, 2'h1, 4'h2, 4'h4, 3'h0, 4'h5, 3'h0, 5'h00, 13'h0000, 1'b0);
		rd(9'h014, 16'hf800);
		rd(9'h040, 16'h001d);
		$display("shift test done");
		wr(9'h008, 16'h0001);
		wr(9'h00c, 16'h0002);
		wr(9'h018, 16'h0004);
		u_seq.issue(4'h1, 2'h1, 4'h2, 4'h3, 3'h0, 4'h6, 3'h2, 5'h00, 13'h0000, 1'b0);
		rd(9'h108, 16'h0003);
		rd(9'h018, 16'h0006);
		$display("indirect test done");
		wr(9'h010, 16'h0003);
		u_seq.issue(4'h8, 2'h0, 4'h0, 4'h0, 3'h0, 4'h0, 3'h0, 5'h00, 13'h0000, 1'b0);
		rd(9'h048, 16'h0009);
		wr(9'h014, 16'h0005);
		u_seq.issue(4'h7, 2'h0, 4'h0, 4'h0, 3'h0, 4'h0, 3'h0, 5'h00, 13'h0000, 1'b0);
		rd(9'h048, 16'h000f);
		wr(9'h040, 16'h001f);
		u_seq.issue(4'h3, 2'h0, 4'h0, 4'h0, 3'h0, 4'h0, 3'h0, 5'h00, 13'h0000, 1'b0);
		rd(9'h040, 16'h001f);
		$display("multiply test done");
		wr(9'h10c, 16'h1234);
		wr(9'h020, 16'h0006);
		pfx <= 4'h2;
		u_seq.issue(4'h8, 2'h0, 4'h0, 4'h3, 3'h0, 4'h0, 3'h0, 5'h00, 13'h0000, 1'b0);
		pfx <= 4'h0;
		rd(9'h01c, 16'h1234);
		rd(9'h020, 16'h0008);
		wr(9'h008, 16'h0007);
		u_seq.issue(4'h9, 2'h0, 4'h2, 4'h3, 3'h0, 4'h0, 3'h0, 5'h00, 13'h0000, 1'b0);
		rd(9'h000, 16'h0003);
		rd(9'h004, 16'h0001);
		bm <= 1'b1;
		u_seq.issue(4'h1, 2'h1, 4'h2, 4'h3, 3'h0, 4'h6, 3'h2, 5'h00, 13'h0000, 1'b0);
		bm <= 1'b0;
		rd(9'h10c, 16'h1209);
		rd(9'h018, 16'h0007);
		$display("prefetch, divide and byte test done");
		end_of_test();
	end
endmodule // aod_datapath_test
bind aod_datapath aod_asserts u_chk (.clock(clock), .reset(reset), .read(read), .write(write),
	.waitrequest(waitrequest), .readdata(readdata), .instr_valid(instr_valid), .instr_done(instr_done));
`default_nettype wire
